/* core/caw_pkg.sv */
// Package for the counter array watchdog: register addresses, field positions,
// reset values and clock source encodings.
// Assumes an 8-bit special function register bus with byte addresses.
package caw_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CONTROL       = 8'hd8;  // counter_control_reg
  localparam logic [7:0] ADDR_MODE          = 8'hd9;  // counter_mode_reg
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'he9;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hf9;
  localparam logic [7:0] ADDR_MOD4_MODE     = 8'hde;
  localparam logic [7:0] ADDR_OFFSET_LOW    = 8'hed;
  localparam logic [7:0] ADDR_COMPARE_HIGH  = 8'hfe;
  // Control register fields
  localparam int CTL_OVF_BIT   = 7;
  localparam int CTL_RUN_BIT   = 6;
  localparam int CTL_M4_BIT    = 4;
  // Mode register fields
  localparam int MD_IDLE_BIT   = 7;
  localparam int MD_WDE_BIT    = 6;
  localparam int MD_LOCK_BIT   = 5;
  localparam int MD_CPS_LSB    = 1;
  localparam int MD_OVFIE_BIT  = 0;
  // Reset values
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [2:0] CPS_RESET      = 3'h0;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] OFFSET_RESET   = 8'h00;
  localparam logic [7:0] MOD4_MODE_RESET = 8'h00;
  // Clock source encodings
  localparam logic [2:0] CPS_DIV12 = 3'h0;
  localparam logic [2:0] CPS_DIV4  = 3'h1;
  localparam logic [2:0] CPS_TICK0 = 3'h2;
  localparam logic [2:0] CPS_EXT   = 3'h3;
  localparam logic [2:0] CPS_SYS   = 3'h4;
  localparam logic [2:0] CPS_EXT8  = 3'h5;
  localparam logic [3:0] DIV12_TERM = 4'hb;
  localparam logic [3:0] DIV4_TERM  = 4'h3;
  localparam logic [3:0] DIV8_TERM  = 4'h7;
endpackage

/* core/caw_watchdog.sv */
// Counter array with its module 4 watchdog and the shared control flags.
// Assumes a single-cycle special function register bus from the CPU on core_clk_i.
//
// Operation
// - Watchdog compare byte is matched against the counter high byte.
// - Low byte overflow during that match issues a watchdog reset.
// - Writing one to module 4 match flag while enabled forces a reset.
// - Timeout is 256 times offset plus 256 minus low byte at update.
// - Clock source and idle suspend are frozen while the watchdog is enabled.
// - Watchdog is active when enable bit or lock bit is set.
// - Lock bit keeps the watchdog enabled until the next system reset.
// - With lock clear, clearing the enable bit disables the watchdog.
// - Reset state: enabled, divide by 12, low byte and offset zero.
// - Counter overflow flag set on 16-bit rollover, sticky until software clears.
// - Compare writes load counter high byte plus offset, ignoring the data.
// - While enabled counter is forced on, counter and module 4 mode writes ignored.
// - Match flags 0 to 3 set by hardware and cleared only by software.
`timescale 1ns/1ps
module caw_watchdog
  import caw_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       cpu_idle_i,
  input  wire logic       tick0_i,
  input  wire logic       ext_clk_i,
  input  wire logic [3:0] match_event_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            wdt_reset_o,
  output logic            counter_irq_o
);
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic [7:0] compare_high;
  logic [7:0] offset_low;
  logic [7:0] mod4_mode;
  logic       ovf_flag;
  logic       run_bit;
  logic [4:0] match_flags;
  logic       idle_bit;
  logic       wde_bit;
  logic       lock_bit;
  logic [2:0] cps;
  logic       ovf_ie;
  logic [3:0] div_cnt;
  logic       tick0_s1, tick0_s2, tick0_s3;
  logic       ext_s1, ext_s2, ext_s3;
  logic       ext_div_en;
  logic [2:0] ext_div;
  logic       wdt_on;
  logic       running;
  logic       cnt_en;
  logic       low_wrap;
  logic       wr_ctl, wr_md, wr_lo, wr_hi, wr_cmp, wr_off, wr_m4;

  // Strobe is an argument so each assign wakes when it drops, not only on address change
  function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] b);
    hit = wr && (a == b);
  endfunction

  assign wr_ctl = hit(sfr_wr_i, sfr_addr_i, ADDR_CONTROL);
  assign wr_md  = hit(sfr_wr_i, sfr_addr_i, ADDR_MODE);
  assign wr_lo  = hit(sfr_wr_i, sfr_addr_i, ADDR_COUNT_LOW);
  assign wr_hi  = hit(sfr_wr_i, sfr_addr_i, ADDR_COUNT_HIGH);
  assign wr_cmp = hit(sfr_wr_i, sfr_addr_i, ADDR_COMPARE_HIGH);
  assign wr_off = hit(sfr_wr_i, sfr_addr_i, ADDR_OFFSET_LOW);
  assign wr_m4  = hit(sfr_wr_i, sfr_addr_i, ADDR_MOD4_MODE);

  assign wdt_on  = wde_bit || lock_bit;
  assign running = run_bit || wdt_on;

  // Pin-side clock inputs pass two flops before the edge detector
  always_ff @(posedge core_clk_i) begin
    tick0_s1 <= tick0_i;
    tick0_s2 <= tick0_s1;
    tick0_s3 <= tick0_s2;
    ext_s1   <= ext_clk_i;
    ext_s2   <= ext_s1;
    ext_s3   <= ext_s2;
  end

  // System clock divider, plus the separate external edge counter of the divide-by-8 path
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0;
      ext_div <= 3'h0;
    end else begin
      if ((cps == CPS_DIV12 && div_cnt == DIV12_TERM) || (cps == CPS_DIV4 && div_cnt == DIV4_TERM))
        div_cnt <= 4'h0;
      else
        div_cnt <= div_cnt + 4'h1;
      if (ext_s2 && !ext_s3)
        ext_div <= ext_div + 3'h1;
    end
  end

  assign ext_div_en = ext_s2 && !ext_s3 && (ext_div == DIV8_TERM[2:0]);

  always_comb begin
    unique case (cps)
      CPS_DIV12: cnt_en = (div_cnt == DIV12_TERM);
      CPS_DIV4:  cnt_en = (div_cnt == DIV4_TERM);
      CPS_TICK0: cnt_en = tick0_s2 && !tick0_s3;
      CPS_EXT:   cnt_en = ext_s2 && !ext_s3;
      CPS_SYS:   cnt_en = 1'b1;
      CPS_EXT8:  cnt_en = ext_div_en;
      default:   cnt_en = 1'b0;
    endcase
    // Idle suspend gates the whole counter, watchdog included
    cnt_en = cnt_en && running && !(idle_bit && cpu_idle_i);
  end

  assign low_wrap = cnt_en && (count_low == 8'hff);

  // Counter; firmware writes are dropped while the watchdog owns it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_low  <= COUNT_RESET;
      count_high <= COUNT_RESET;
    end else begin
      if (wr_lo && !wdt_on)
        count_low <= sfr_wdata_i;
      else if (cnt_en)
        count_low <= count_low + 8'h01;
      if (wr_hi && !wdt_on)
        count_high <= sfr_wdata_i;
      else if (low_wrap)
        count_high <= count_high + 8'h01;
    end
  end

  // Mode register: lock is sticky, clock source and idle frozen while enabled
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wde_bit  <= 1'b1;
      lock_bit <= 1'b0;
      idle_bit <= 1'b0;
      cps      <= CPS_RESET;
      ovf_ie   <= 1'b0;
    end else if (wr_md) begin
      lock_bit <= lock_bit || sfr_wdata_i[MD_LOCK_BIT];
      wde_bit  <= sfr_wdata_i[MD_WDE_BIT];
      ovf_ie   <= sfr_wdata_i[MD_OVFIE_BIT];
      if (!wdt_on) begin
        idle_bit <= sfr_wdata_i[MD_IDLE_BIT];
        cps      <= sfr_wdata_i[MD_CPS_LSB +: 3];
      end
    end
  end

  // Module 4 mode register holds its value but is unused while the watchdog owns it
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      mod4_mode <= MOD4_MODE_RESET;
    else if (wr_m4 && !wdt_on)
      mod4_mode <= sfr_wdata_i;
  end

  // Offset and compare bytes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      offset_low   <= OFFSET_RESET;
      compare_high <= OFFSET_RESET;
    end else begin
      if (wr_off)
        offset_low <= sfr_wdata_i;
      if (wr_cmp)
        compare_high <= count_high + offset_low;
    end
  end

  // Control flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ovf_flag    <= CONTROL_RESET[CTL_OVF_BIT];
      run_bit     <= CONTROL_RESET[CTL_RUN_BIT];
      match_flags <= CONTROL_RESET[4:0];
    end else begin
      if (wr_ctl) begin
        ovf_flag    <= sfr_wdata_i[CTL_OVF_BIT];
        run_bit     <= sfr_wdata_i[CTL_RUN_BIT];
        match_flags <= sfr_wdata_i[4:0];
      end
      if (low_wrap && count_high == 8'hff)
        ovf_flag <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (match_event_i[i])
          match_flags[i] <= 1'b1;
      end
    end
  end

  // Watchdog reset, one cycle pulse from a flop
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      wdt_reset_o <= 1'b0;
    else
      wdt_reset_o <= wdt_on && ((low_wrap && compare_high == count_high)
                     || (wr_ctl && sfr_wdata_i[CTL_M4_BIT]));
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      counter_irq_o <= 1'b0;
    else
      counter_irq_o <= ovf_flag && ovf_ie;
  end

  // Read data; the run bit reads as software left it, not as forced
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        ADDR_CONTROL:      sfr_rdata_o <= {ovf_flag, run_bit, 1'b0, match_flags};
        ADDR_MODE:         sfr_rdata_o <= {idle_bit, wde_bit, lock_bit, 1'b0, cps, ovf_ie};
        ADDR_COUNT_LOW:    sfr_rdata_o <= count_low;
        ADDR_COUNT_HIGH:   sfr_rdata_o <= count_high;
        ADDR_MOD4_MODE:    sfr_rdata_o <= mod4_mode;
        ADDR_OFFSET_LOW:   sfr_rdata_o <= offset_low;
        ADDR_COMPARE_HIGH: sfr_rdata_o <= compare_high;
        default:           sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

/* verif/caw_watchdog_sva.sv */
// Port checker for caw_watchdog.
// Assumes bus strobes are synchronous to core_clk_i.
`timescale 1ns/1ps
module caw_watchdog_sva
  import caw_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       wdt_reset_o,
  input wire logic       counter_irq_o
);
  logic wde;
  logic lock;
  logic ie;
  logic en;
  assign en = wde | lock;
  // Lock is ORed in since only reset may drop it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wde  <= 1'b1;
      lock <= 1'b0;
      ie   <= 1'b0;
    end else if (sfr_wr_i && sfr_addr_i == ADDR_MODE) begin
      wde  <= sfr_wdata_i[MD_WDE_BIT];
      lock <= lock | sfr_wdata_i[MD_LOCK_BIT];
      ie   <= sfr_wdata_i[MD_OVFIE_BIT];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  sequence s_cw;
    sfr_wr_i && sfr_addr_i == ADDR_CONTROL;
  endsequence
  sequence s_cr;
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == ADDR_CONTROL;
  endsequence
  a_reset_quiet: assert property (
    rst_i |=> !wdt_reset_o && !counter_irq_o && sfr_rdata_o == 8'h00) else $error("not idle");
  a_force_reset: assert property (disable iff (rst_i)
    s_cw ##0 (sfr_wdata_i[CTL_M4_BIT] && en) |=> wdt_reset_o) else $error("no forced reset");
  a_reset_when_on: assert property (disable iff (rst_i)
    wdt_reset_o |-> $past(en)) else $error("reset while off");
  a_rdata_hold: assert property (disable iff (rst_i)
    !sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved");
  a_unmapped_zero: assert property (disable iff (rst_i)
    sfr_rd_i && sfr_addr_i == 8'h00 |=> sfr_rdata_o == 8'h00) else $error("unmapped not zero");
  a_spare_zero: assert property (disable iff (rst_i)
    s_cr |=> !sfr_rdata_o[5]) else $error("spare bit set");
  a_run_readback: assert property (disable iff (rst_i)
    s_cw ##1 !sfr_wr_i ##1 s_cr |=> sfr_rdata_o[CTL_RUN_BIT] == $past(sfr_wdata_i[6], 3))
    else $error("run bit lost");
  a_irq_gated: assert property (disable iff (rst_i)
    counter_irq_o |-> $past(ie)) else $error("irq while masked");
endmodule

/* verif/caw_cpu_model.sv */
// Firmware model: owns the register bus of the watchdog.
// Assumes accesses are taken on the rising edge of core_clk_i.
`timescale 1ns/1ps
module caw_cpu_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] sfr_rdata_o,
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  output logic      [7:0] sfr_wdata_o
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  // Strobe stands for one taking edge only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_o <= a;
    sfr_wdata_o <= d;
    sfr_wr_o <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_o <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask
endmodule

/* verif/caw_watchdog_bench.sv */
// Bench for caw_watchdog; timer and external clock inputs driven by a task, idle input set inline.
// Assumes caw_cpu_model drives the register bus.
`timescale 1ns/1ps
module caw_watchdog_bench
  import caw_pkg::*;
;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic       sfr_wr_i, sfr_rd_i, wdt_reset_o, counter_irq_o;
  logic [3:0] match_event_i = 4'h0;
  logic       cpu_idle_i = 1'b0;
  logic       tick0_i = 1'b0;
  logic       ext_clk_i = 1'b0;
  int         error_cnt, check_count, cyc, t0;
  caw_cpu_model caw_cpu_model_inst (.core_clk_i(core_clk_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i));
  caw_watchdog caw_watchdog_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .cpu_idle_i(cpu_idle_i), .tick0_i(tick0_i),
    .ext_clk_i(ext_clk_i),
    .match_event_i(match_event_i), .sfr_rdata_o(sfr_rdata_o), .wdt_reset_o(wdt_reset_o),
    .counter_irq_o(counter_irq_o));
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    caw_cpu_model_inst.wr(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    caw_cpu_model_inst.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // Two cycles high, two low, so the two-flop sync sees every level
  task automatic pulse_in(input int n, input bit use_ext);
    repeat (n) begin
      @(posedge core_clk_i);
      ext_clk_i <= use_ext;
      tick0_i   <= !use_ext;
      repeat (2) @(posedge core_clk_i);
      ext_clk_i <= 1'b0;
      tick0_i   <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  task automatic do_reset();
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask
  // Sync and prescaler phase blur the exact edge, hence the window
  task automatic wait_wdt(input int e);
    int n;
    n = 0;
    while (wdt_reset_o !== 1'b1 && n < 8000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    check_count++;
    if (cyc - t0 < e - 24 || cyc - t0 > e + 24) begin
      error_cnt++;
      $display("[ERR] timeout expected %0d seen %0d", e, cyc - t0);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk_i);
    error_cnt++;
    end_sim();
  end
  initial begin
    do_reset();
    t0 = cyc;
    rchk(ADDR_CONTROL, CONTROL_RESET);
    rchk(ADDR_MODE, 8'h40);
    rchk(ADDR_OFFSET_LOW, OFFSET_RESET);
    rchk(8'h00, 8'h00);
    wait_wdt(12 * 256);
    do_reset();
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hf0);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_OFFSET_LOW, 8'h02);
    rchk(ADDR_COUNT_LOW, 8'hf0);
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_COMPARE_HIGH, 8'h55);
    t0 = cyc;
    wr(ADDR_MODE, 8'hc8);
    rchk(ADDR_MODE, 8'h40);
    wr(ADDR_COUNT_HIGH, 8'haa);
    rchk(ADDR_COUNT_HIGH, 8'h00);
    rchk(ADDR_COMPARE_HIGH, 8'h02);
    wr(ADDR_MOD4_MODE, 8'h5a);
    rchk(ADDR_MOD4_MODE, 8'h00);
    wait_wdt(12 * (256 * 2 + 256 - 8'hf0));
    do_reset();
    wr(ADDR_MODE, 8'h60);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    #1 chk("forced reset", 8'h01, {7'h00, wdt_reset_o});
    do_reset();
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    #1 chk("reset when off", 8'h00, {7'h00, wdt_reset_o});
    @(posedge core_clk_i);
    match_event_i <= 4'h5;
    @(posedge core_clk_i);
    match_event_i <= 4'h0;
    rchk(ADDR_CONTROL, 8'h15);
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_CONTROL, 8'h40);
    repeat (20) @(posedge core_clk_i);
    rchk(ADDR_CONTROL, 8'hc0);
    chk("irq", 8'h01, {7'h00, counter_irq_o});
    wr(ADDR_CONTROL, 8'h40);
    rchk(ADDR_CONTROL, 8'h40);
    chk("irq", 8'h00, {7'h00, counter_irq_o});
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MOD4_MODE, 8'h5a);
    rchk(ADDR_MOD4_MODE, 8'h5a);
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h40);
    pulse_in(3, 1'b0);
    rchk(ADDR_COUNT_LOW, 8'h03);
    @(posedge core_clk_i);
    cpu_idle_i <= 1'b1;
    pulse_in(2, 1'b0);
    rchk(ADDR_COUNT_LOW, 8'h03);
    @(posedge core_clk_i);
    cpu_idle_i <= 1'b0;
    wr(ADDR_MODE, 8'h0a);
    pulse_in(16, 1'b1);
    rchk(ADDR_COUNT_LOW, 8'h05);
    end_sim();
  end
endmodule
bind caw_watchdog caw_watchdog_sva caw_watchdog_sva_inst (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .wdt_reset_o(wdt_reset_o),
  .counter_irq_o(counter_irq_o));
